//--- hw/mpp_port_pins.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mpp_params.svh"

// What this block does
// - output ports drive data OR pattern bits
// - mixed port outputs data OR generator bits
// - realtime pulse is channel 0 OR channel 1
// - output ports float until first data write
// - second port bits 0,2 tristated by pattern gen
// - mixed bit 3 tristated by realtime generator
// - mixed bit 4 tristate selected by ctl bit 7
// - direction bits reset to input
// - sink port upper directional, lower open drain
// - serial enable overrides sink lower data
// - irq port lower inputs, upper outputs
// - external irq requests on falling edge
// - general bit 4 raises irq and nmi
// - analog port lower inputs wake, upper outputs
// - wake port per bit direction and wake
// - general port per bit direction, alt mux
// - open drain port pulls low or releases
// - da gate pins high at reset
module mpp_port_pins
   import mpp_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // pattern and realtime generators
   input  wire logic [18:0] pattern_gen_output,
   input  wire logic [1:0]  pattern_gen_tri,
   input  wire logic [7:3]  rtg_ch0_out,
   input  wire logic [7:3]  rtg_ch1_out,
   input  wire logic [1:0]  rtg_tri,
   // two wire serial channel
   input  wire logic [3:0]  serial_out,
   input  wire logic [3:0]  serial_oe,
   // general port alternate outputs
   input  wire logic [7:1]  gen_alt_out,
   // first and second output ports
   output logic [7:0]       first_port_out,
   output logic [7:0]       first_port_oe,
   output logic [7:0]       second_port_out,
   output logic [7:0]       second_port_oe,
   // mixed pulse port
   input  wire logic [7:0]  mixed_port_in,
   output logic [7:0]       mixed_port_out,
   output logic [7:0]       mixed_port_oe,
   // sink drive port
   input  wire logic [7:0]  sink_port_in,
   output logic [7:0]       sink_port_out,
   output logic [7:0]       sink_port_oe,
   // interrupt pwm port
   input  wire logic [1:0]  irq_port_in,
   output logic [7:2]       irq_port_out,
   output logic [7:2]       irq_port_oe,
   // analog shared port
   input  wire logic [3:0]  ana_port_in,
   output logic [7:4]       ana_port_out,
   output logic [7:4]       ana_port_oe,
   // open drain port
   output logic [7:0]       od_port_out,
   output logic [7:0]       od_port_oe,
   // general function port
   input  wire logic [7:1]  gen_port_in,
   output logic [7:1]       gen_port_out,
   output logic [7:1]       gen_port_oe,
   // wake capable port
   input  wire logic [7:0]  wake_port_in,
   output logic [7:0]       wake_port_out,
   output logic [7:0]       wake_port_oe,
   // event pulses
   output logic             ext_irq_zero,
   output logic             ext_irq_two,
   output logic             ext_irq_one,
   output logic             nmi_req,
   output logic             standby_release
);

   //*****************************************
   // pin logic
   //*****************************************
   mpp_state_t  s_reg;
   mpp_state_t  s_next;
   logic [7:3]  realtime_pulse_output;
   logic [7:0]  mixed_alt;
   logic [7:0]  mixed_rd;
   logic [7:0]  sink_rd;
   logic [7:1]  gen_rd;
   logic [7:0]  wake_rd;
   logic        wr_en;
   logic        rd_setup;

   // realtime pulse merges both channels
   assign realtime_pulse_output = rtg_ch0_out | rtg_ch1_out;
   assign mixed_alt = {realtime_pulse_output, pattern_gen_output[18:16]};

   // output only ports
   assign first_port_out = s_reg.first_data
                         | pattern_gen_output[7:0];
   assign first_port_oe = {8{s_reg.first_written}};
   assign second_port_out = s_reg.second_data
                          | pattern_gen_output[15:8];
   always_comb
   begin
      second_port_oe = {8{s_reg.second_written}};
      if (pattern_gen_tri[0])
         second_port_oe[0] = 1'b0;
      if (pattern_gen_tri[1])
         second_port_oe[2] = 1'b0;
   end

   // mixed pulse port
   assign mixed_port_out = s_reg.mixed_data | mixed_alt;
   always_comb
   begin
      mixed_port_oe = s_reg.mixed_dir;
      if (rtg_tri[0])
         mixed_port_oe[3] = 1'b0;
      if (s_reg.rtg_ctl[`MPP_RTG_TRI4_SEL_BIT] && rtg_tri[1])
         mixed_port_oe[4] = 1'b0;
   end

   // sink drive port, lower nibble open drain
   assign sink_port_out = {s_reg.sink_data[7:4], 4'h0};
   always_comb
   begin
      sink_port_oe[7:4] = s_reg.sink_dir;
      sink_port_oe[3:0] = ~s_reg.sink_data[3:0];
      for (int i = 0; i < 4; i++)
         if (serial_oe[i])
            sink_port_oe[i] = ~serial_out[i];
   end

   // interrupt pwm port outputs, da gate pins
   assign irq_port_out = s_reg.irq_data;
   assign irq_port_oe = {2'b11, {4{s_reg.irq_written}}};

   // analog shared port upper outputs
   assign ana_port_out = s_reg.ana_data;
   assign ana_port_oe = {4{s_reg.ana_written}};

   // open drain port
   assign od_port_out = 8'h00;
   assign od_port_oe = ~s_reg.od_data;

   // general function port, alternate mux
   assign gen_port_out = (s_reg.gen_fsel & gen_alt_out)
                       | (~s_reg.gen_fsel & s_reg.gen_data);
   assign gen_port_oe = s_reg.gen_dir;

   // wake capable port
   assign wake_port_out = s_reg.wake_data;
   assign wake_port_oe = s_reg.wake_dir;

   // pin read mux: inputs show pin, outputs data
   assign mixed_rd = (s_reg.mixed_dir & s_reg.mixed_data)
                   | (~s_reg.mixed_dir & mixed_port_in);
   assign sink_rd = {(s_reg.sink_dir & s_reg.sink_data[7:4])
                    | (~s_reg.sink_dir & sink_port_in[7:4]),
                     sink_port_in[3:0]};
   assign gen_rd = (s_reg.gen_dir & s_reg.gen_data)
                 | (~s_reg.gen_dir & gen_port_in);
   assign wake_rd = (s_reg.wake_dir & s_reg.wake_data)
                  | (~s_reg.wake_dir & wake_port_in);

   // apb decode
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign pready = 1'b1;
   assign prdata = s_reg.rdata;
   assign pslverr = s_reg.slverr;

   // event outputs
   assign ext_irq_zero = s_reg.irq_zero_pulse;
   assign ext_irq_two = s_reg.irq_two_pulse;
   assign ext_irq_one = s_reg.irq_one_pulse;
   assign nmi_req = s_reg.nmi_pulse;
   assign standby_release = s_reg.standby_pulse;

   //*****************************************
   // next state
   //*****************************************
   always_comb
   begin
      s_next = s_reg;
      // edge detectors
      s_next.irq_prev = irq_port_in;
      s_next.gen_irq_prev = gen_port_in[`MPP_GEN_IRQ_BIT];
      s_next.ana_prev = ana_port_in;
      s_next.wake_prev = wake_port_in;
      s_next.irq_zero_pulse = s_reg.irq_prev[0]
                            & ~irq_port_in[0];
      s_next.irq_two_pulse = s_reg.irq_prev[1]
                           & ~irq_port_in[1];
      s_next.irq_one_pulse = s_reg.gen_irq_prev
                           & ~gen_port_in[`MPP_GEN_IRQ_BIT];
      s_next.nmi_pulse = s_next.irq_one_pulse;
      s_next.standby_pulse =
         (|(s_reg.ana_wake_en & (s_reg.ana_prev ^ ana_port_in)))
       | (|(s_reg.wake_en & ~s_reg.wake_dir
            & (s_reg.wake_prev ^ wake_port_in)));
      // register reads sampled in setup phase
      if (rd_setup)
      begin
         s_next.rdata = 32'h0000_0000;
         s_next.slverr = 1'b0;
         case (paddr)
            `MPP_OFS_FIRST_DATA:  s_next.rdata[7:0] = s_reg.first_data;
            `MPP_OFS_SECOND_DATA: s_next.rdata[7:0] = s_reg.second_data;
            `MPP_OFS_MIXED_DATA:  s_next.rdata[7:0] = mixed_rd;
            `MPP_OFS_MIXED_DIR:   s_next.rdata[7:0] = s_reg.mixed_dir;
            `MPP_OFS_SINK_DATA:   s_next.rdata[7:0] = sink_rd;
            `MPP_OFS_SINK_DIR:    s_next.rdata[7:4] = s_reg.sink_dir;
            `MPP_OFS_IRQ_DATA:
               s_next.rdata[7:0] = {s_reg.irq_data, irq_port_in};
            `MPP_OFS_ANA_DATA:
               s_next.rdata[7:0] = {s_reg.ana_data, ana_port_in};
            `MPP_OFS_OD_DATA:     s_next.rdata[7:0] = s_reg.od_data;
            `MPP_OFS_GEN_DATA:    s_next.rdata[7:1] = gen_rd;
            `MPP_OFS_GEN_DIR:     s_next.rdata[7:1] = s_reg.gen_dir;
            `MPP_OFS_WAKE_DATA:   s_next.rdata[7:0] = wake_rd;
            `MPP_OFS_WAKE_DIR:    s_next.rdata[7:0] = s_reg.wake_dir;
            `MPP_OFS_WAKE_EN:     s_next.rdata[7:0] = s_reg.wake_en;
            `MPP_OFS_RTG_CTL:     s_next.rdata[7:0] = s_reg.rtg_ctl;
            `MPP_OFS_ANA_WAKE_EN: s_next.rdata[3:0] = s_reg.ana_wake_en;
            `MPP_OFS_GEN_FSEL:    s_next.rdata[7:1] = s_reg.gen_fsel;
            default:              s_next.slverr = 1'b1;
         endcase
      end
      // register writes in access phase
      if (wr_en)
      begin
         case (paddr)
            `MPP_OFS_FIRST_DATA:
            begin
               s_next.first_data = pwdata[7:0];
               s_next.first_written = 1'b1;
            end
            `MPP_OFS_SECOND_DATA:
            begin
               s_next.second_data = pwdata[7:0];
               s_next.second_written = 1'b1;
            end
            `MPP_OFS_MIXED_DATA:  s_next.mixed_data = pwdata[7:0];
            `MPP_OFS_MIXED_DIR:   s_next.mixed_dir = pwdata[7:0];
            `MPP_OFS_SINK_DATA:   s_next.sink_data = pwdata[7:0];
            `MPP_OFS_SINK_DIR:    s_next.sink_dir = pwdata[7:4];
            `MPP_OFS_IRQ_DATA:
            begin
               s_next.irq_data = pwdata[7:2];
               s_next.irq_written = 1'b1;
            end
            `MPP_OFS_ANA_DATA:
            begin
               s_next.ana_data = pwdata[7:4];
               s_next.ana_written = 1'b1;
            end
            `MPP_OFS_OD_DATA:     s_next.od_data = pwdata[7:0];
            `MPP_OFS_GEN_DATA:    s_next.gen_data = pwdata[7:1];
            `MPP_OFS_GEN_DIR:     s_next.gen_dir = pwdata[7:1];
            `MPP_OFS_WAKE_DATA:   s_next.wake_data = pwdata[7:0];
            `MPP_OFS_WAKE_DIR:    s_next.wake_dir = pwdata[7:0];
            `MPP_OFS_WAKE_EN:     s_next.wake_en = pwdata[7:0];
            `MPP_OFS_RTG_CTL:     s_next.rtg_ctl = pwdata[7:0];
            `MPP_OFS_ANA_WAKE_EN: s_next.ana_wake_en = pwdata[3:0];
            `MPP_OFS_GEN_FSEL:    s_next.gen_fsel = pwdata[7:1];
            default:              s_next.slverr = s_reg.slverr;
         endcase
      end
   end

   //*****************************************
   // state register
   //*****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.mixed_dir <= `MPP_RST_DIR;
         s_reg.wake_dir <= `MPP_RST_DIR;
         s_reg.irq_data <= 6'(`MPP_RST_IRQ_DATA >> 2);
         s_reg.od_data <= `MPP_RST_OD_DATA;
         s_reg.rtg_ctl <= `MPP_RST_DATA;
         s_reg.irq_prev <= 2'h3;
         s_reg.gen_irq_prev <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   //*****************************************
   // assertions
   //*****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence fall_irq0;
      irq_port_in[0] ##1 !irq_port_in[0];
   endsequence
   sequence fall_gen4;
      gen_port_in[4] ##1 !gen_port_in[4];
   endsequence

   a_first_or_pattern: assert property (
      first_port_out == ($past(s_next.first_data)
                        | pattern_gen_output[7:0]) || $past(wr_en))
      else $error("first port not data or pattern");
   a_first_float: assert property (
      !s_reg.first_written |-> first_port_oe == 8'h00)
      else $error("first port driven before write");
   a_first_wr_drive: assert property (
      (wr_en && paddr == `MPP_OFS_FIRST_DATA) |=> first_port_oe == 8'hff)
      else $error("first port not driven after write");
   a_second_tri: assert property (
      pattern_gen_tri[0] |-> !second_port_oe[0])
      else $error("second port bit 0 not released");
   a_mixed_tri3: assert property (
      rtg_tri[0] |-> !mixed_port_oe[3])
      else $error("mixed bit 3 not released");
   a_mixed_tri4: assert property (
      (rtg_tri[1] && !s_reg.rtg_ctl[7]) |-> mixed_port_oe[4]
                                            == s_reg.mixed_dir[4])
      else $error("mixed bit 4 tristate without select");
   a_rto_merge: assert property (
      mixed_port_out[7:3] == (s_reg.mixed_data[7:3]
                            | rtg_ch0_out | rtg_ch1_out))
      else $error("realtime merge wrong");
   a_irq0_fall: assert property (
      fall_irq0 |=> ext_irq_zero)
      else $error("missing irq zero on falling edge");
   a_irq0_quiet: assert property (
      ext_irq_zero |-> $past(irq_port_in[0], 2) && !$past(irq_port_in[0]))
      else $error("irq zero without falling edge");
   a_nmi_pair: assert property (
      fall_gen4 |=> ext_irq_one && nmi_req)
      else $error("general bit 4 edge lost");
   a_serial_ovr: assert property (
      (serial_oe[1] && !serial_out[1]) |-> sink_port_oe[1]
                                          && !sink_port_out[1])
      else $error("serial low not driven");
   a_da_gate_high: assert property (
      irq_port_oe[7:6] == 2'b11)
      else $error("da gate pins not driven");
   a_od_low_only: assert property (
      od_port_out == 8'h00 && od_port_oe == ~s_reg.od_data)
      else $error("open drain drives high");
   // analog outputs stay released until first write
   a_ana_float: assert property (
      !s_reg.ana_written |-> ana_port_oe == 4'h0)
      else $error("analog outputs driven before write");
   // no wake source enabled, no standby release
   a_wake_quiet: assert property (
      (s_reg.ana_wake_en == 4'h0
       && (s_reg.wake_en & ~s_reg.wake_dir) == 8'h00) |=> !standby_release)
      else $error("standby release without enabled source");

endmodule

`default_nettype wire

//--- pkg/mpp_params.svh
`ifndef MPP_PARAMS_SVH
`define MPP_PARAMS_SVH
// register byte offsets
`define MPP_OFS_FIRST_DATA   8'h00
`define MPP_OFS_SECOND_DATA  8'h04
`define MPP_OFS_MIXED_DATA   8'h08
`define MPP_OFS_MIXED_DIR    8'h0c
`define MPP_OFS_SINK_DATA    8'h10
`define MPP_OFS_SINK_DIR     8'h14
`define MPP_OFS_IRQ_DATA     8'h18
`define MPP_OFS_ANA_DATA     8'h1c
`define MPP_OFS_OD_DATA      8'h20
`define MPP_OFS_GEN_DATA     8'h24
`define MPP_OFS_GEN_DIR      8'h28
`define MPP_OFS_WAKE_DATA    8'h2c
`define MPP_OFS_WAKE_DIR     8'h30
`define MPP_OFS_WAKE_EN      8'h34
`define MPP_OFS_RTG_CTL      8'h38
`define MPP_OFS_ANA_WAKE_EN  8'h3c
`define MPP_OFS_GEN_FSEL     8'h40
// field positions
`define MPP_RTG_TRI4_SEL_BIT 7
`define MPP_GEN_IRQ_BIT      4
// reset values
`define MPP_RST_DATA         8'h00
`define MPP_RST_DIR          8'h00
`define MPP_RST_IRQ_DATA     8'hc0
`define MPP_RST_OD_DATA      8'hff
`endif

//--- pkg/mpp_pkg.sv
`default_nettype none
package mpp_pkg;
   typedef struct packed {
      logic [7:0]  first_data;
      logic [7:0]  second_data;
      logic        first_written;
      logic        second_written;
      logic [7:0]  mixed_data;
      logic [7:0]  mixed_dir;
      logic [7:0]  sink_data;
      logic [7:4]  sink_dir;
      logic [7:2]  irq_data;
      logic        irq_written;
      logic [7:4]  ana_data;
      logic        ana_written;
      logic [7:0]  od_data;
      logic [7:1]  gen_data;
      logic [7:1]  gen_dir;
      logic [7:1]  gen_fsel;
      logic [7:0]  wake_data;
      logic [7:0]  wake_dir;
      logic [7:0]  wake_en;
      logic [3:0]  ana_wake_en;
      logic [7:0]  rtg_ctl;
      logic [1:0]  irq_prev;
      logic        gen_irq_prev;
      logic [3:0]  ana_prev;
      logic [7:0]  wake_prev;
      logic        irq_zero_pulse;
      logic        irq_two_pulse;
      logic        irq_one_pulse;
      logic        nmi_pulse;
      logic        standby_pulse;
      logic [31:0] rdata;
      logic        slverr;
   } mpp_state_t;
endpackage
`default_nettype wire

//--- tb/mpp_board.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************
// board circuitry at the port pins
// ************************************
module mpp_board (
   // design pin drive
   input  wire logic [7:0] mixed_out,
   input  wire logic [7:0] mixed_oe,
   input  wire logic [7:0] sink_out,
   input  wire logic [7:0] sink_oe,
   input  wire logic [7:0] wake_out,
   input  wire logic [7:0] wake_oe,
   // board side drive
   input  wire logic [7:0] ext_drv,
   // resolved pin levels
   output logic [7:0]      mixed_in,
   output logic [7:0]      sink_in,
   output logic [7:0]      wake_in
);
   // driven pins follow the design, released pins follow the board
   assign mixed_in = (mixed_oe & mixed_out) | (~mixed_oe & ext_drv);
   assign wake_in  = (wake_oe & wake_out) | (~wake_oe & ext_drv);
   assign sink_in[7:4] = (sink_oe[7:4] & sink_out[7:4])
                       | (~sink_oe[7:4] & ext_drv[7:4]);
   // wired-and with pull-up on the open drain nibble
   assign sink_in[3:0] = ~(sink_oe[3:0] & ~sink_out[3:0]) & ext_drv[3:0];
endmodule
`default_nettype wire

//--- tb/tb_mcu_port_pin_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpp_params.svh"
module tb_mcu_port_pin_logic;
   import mpp_pkg::*;
   // ************************************
   // signals and instances
   // ************************************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, fo, foe, so, soe, mo, moe, mi, si, sko, skoe, wo, woe;
   logic [7:0] wi, oo, ooe, ext_drv, d1, d2, e8;
   logic [31:0] pwdata, prdata, rd, pat;
   logic [1:0] pg_tri, rtri, irq_in;
   logic [7:3] ch0, ch1;
   logic [3:0] ser_o, ser_oe, ana_in;
   logic [7:4] ao, aoe;
   logic [7:1] gen_in, galt, go, goe;
   logic [7:2] io, ioe;
   wire logic [4:0] ev;
   logic [4:0] ev_exp [5] = '{5'h10, 5'h08, 5'h06, 5'h01, 5'h01};
   integer seed;
   int n_errors, checks, cyc;
   mpp_port_pins uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .pattern_gen_output(pat[18:0]), .pattern_gen_tri(pg_tri),
      .rtg_ch0_out(ch0), .rtg_ch1_out(ch1), .rtg_tri(rtri),
      .serial_out(ser_o), .serial_oe(ser_oe), .gen_alt_out(galt),
      .first_port_out(fo), .first_port_oe(foe), .second_port_out(so),
      .second_port_oe(soe), .mixed_port_in(mi), .mixed_port_out(mo),
      .mixed_port_oe(moe), .sink_port_in(si), .sink_port_out(sko),
      .sink_port_oe(skoe), .irq_port_in(irq_in), .irq_port_out(io),
      .irq_port_oe(ioe), .ana_port_in(ana_in), .ana_port_out(ao),
      .ana_port_oe(aoe), .od_port_out(oo), .od_port_oe(ooe),
      .gen_port_in(gen_in), .gen_port_out(go), .gen_port_oe(goe),
      .wake_port_in(wi), .wake_port_out(wo), .wake_port_oe(woe),
      .ext_irq_zero(ev[4]), .ext_irq_two(ev[3]), .ext_irq_one(ev[2]),
      .nmi_req(ev[1]), .standby_release(ev[0]));
   mpp_board board (.mixed_out(mo), .mixed_oe(moe), .sink_out(sko),
      .sink_oe(skoe), .wake_out(wo), .wake_oe(woe), .ext_drv(ext_drv),
      .mixed_in(mi), .sink_in(si), .wake_in(wi));
   // ************************************
   // clock, timeout and tasks
   // ************************************
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // cut a hang short
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         final_report;
      end
   end
   task final_report;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle;
      @(posedge pclk);
      #1;
   endtask
   // falling pin, pulse in the next cycle for one cycle only
   task edge_chk(input int k);
      @(posedge pclk);
      case (k)
         0: irq_in[0] <= 1'b0;
         1: irq_in[1] <= 1'b0;
         2: gen_in[4] <= 1'b0;
         3: ana_in[0] <= 1'b0;
         default: ext_drv[2] <= 1'b0;
      endcase
      @(posedge pclk);
      #1;
      chk(32'(ev), 32'(ev_exp[k]));
      @(posedge pclk);
      #1;
      chk(32'(ev), 32'h0);
      @(posedge pclk);
      irq_in <= 2'b11;
      gen_in <= 7'h7f;
      ana_in <= 4'hf;
      ext_drv <= 8'hff;
      repeat (4) @(posedge pclk);
   endtask
   // ************************************
   // main sequence
   // ************************************
   initial
   begin
      seed = 32'hd0ad8f8e;
      {psel, penable, pwrite, paddr, pwdata, pg_tri, rtri} = '0;
      {pat, ch0, ch1, ser_o, ser_oe, galt, cyc} = '0;
      {irq_in, gen_in, ana_in, ext_drv} = '1;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      chk(32'({foe, soe, moe, woe}), 32'h0);
      chk(32'({ooe, aoe, goe}), 32'h0);
      chk(32'({ioe, io[7:6]}), 32'h0000_00c3);
      apb(1'b0, `MPP_OFS_RTG_CTL, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h0);
      $display("test reset done");
      repeat (4)
      begin
         d1 = $random(seed);
         d2 = $random(seed);
         @(posedge pclk);
         pat <= $random(seed);
         galt <= $random(seed);
         apb(1'b1, `MPP_OFS_FIRST_DATA, 32'(d1));
         apb(1'b1, `MPP_OFS_SECOND_DATA, 32'(d2));
         settle;
         chk(32'({foe, soe}), 32'h0000_ffff);
         chk(32'({fo, so}), 32'({d1 | pat[7:0], d2 | pat[15:8]}));
         @(posedge pclk);
         pg_tri <= 2'b11;
         settle;
         chk(32'(soe), 32'h0000_00fa);
         @(posedge pclk);
         pg_tri <= 2'b00;
      end
      $display("test output ports done");
      d1 = $random(seed);
      ch0 <= $random(seed);
      ch1 <= $random(seed);
      ext_drv <= $random(seed);
      apb(1'b1, `MPP_OFS_MIXED_DIR, 32'h0000_00ff);
      apb(1'b1, `MPP_OFS_MIXED_DATA, 32'(d1));
      settle;
      chk(32'(mo), 32'(d1 | {ch0 | ch1, pat[18:16]}));
      @(posedge pclk);
      rtri <= 2'b11;
      settle;
      chk(32'(moe), 32'h0000_00f7);
      apb(1'b1, `MPP_OFS_RTG_CTL, 32'h0000_0080);
      settle;
      chk(32'(moe), 32'h0000_00e7);
      apb(1'b1, `MPP_OFS_MIXED_DIR, 32'h0000_000f);
      apb(1'b0, `MPP_OFS_MIXED_DATA, 32'h0);
      chk(rd, 32'((d1 & 8'h0f) | (ext_drv & 8'hf0)));
      apb(1'b0, `MPP_OFS_MIXED_DATA, 32'h0);
      chk(rd, 32'((d1 & 8'h0f) | (ext_drv & 8'hf0)));
      $display("test mixed port done");
      d2 = $random(seed);
      apb(1'b1, `MPP_OFS_SINK_DATA, 32'(d2));
      apb(1'b1, `MPP_OFS_SINK_DIR, 32'h0000_00ff);
      settle;
      chk(32'({skoe, sko}), 32'({4'hf, ~d2[3:0], d2[7:4], 4'h0}));
      @(posedge pclk);
      ser_o <= $random(seed);
      ser_oe <= 4'h5;
      settle;
      chk(32'(skoe[3:0]), 32'((4'h5 & ~ser_o) | (4'ha & ~d2[3:0])));
      // open drain nibble reads the wired pin level
      e8 = {d2[7:4], ext_drv[3:0] & ~((4'h5 & ~ser_o) | (4'ha & ~d2[3:0]))};
      apb(1'b0, `MPP_OFS_SINK_DATA, 32'h0);
      chk(rd, 32'(e8));
      d1 = $random(seed);
      apb(1'b1, `MPP_OFS_OD_DATA, 32'(d1));
      apb(1'b1, `MPP_OFS_IRQ_DATA, 32'h0000_003c);
      settle;
      chk(32'({ooe, oo}), 32'({~d1, 8'h00}));
      chk(32'({ioe, io}), 32'h0000_0fcf);
      apb(1'b0, `MPP_OFS_IRQ_DATA, 32'h0);
      chk(rd, 32'h0000_003f);
      apb(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      // general port: upper nibble out, bits 5:4 alternate
      d1 = $random(seed);
      d2 = ({galt, 1'b0} & 8'h30) | (d1 & 8'hcf);
      apb(1'b1, `MPP_OFS_GEN_DATA, 32'(d1));
      apb(1'b1, `MPP_OFS_GEN_DIR, 32'h0000_00f0);
      apb(1'b1, `MPP_OFS_GEN_FSEL, 32'h0000_0030);
      apb(1'b1, `MPP_OFS_ANA_DATA, 32'h0000_00a0);
      settle;
      chk(32'({goe, go}), 32'({7'h78, d2[7:1]}));
      chk(32'({aoe, ao}), 32'h0000_00fa);
      apb(1'b0, `MPP_OFS_GEN_DATA, 32'h0);
      chk(rd, 32'({d1[7:4], 3'h7, 1'b0}));
      apb(1'b0, `MPP_OFS_ANA_DATA, 32'h0);
      chk(rd, 32'h0000_00af);
      $display("test drive ports done");
      apb(1'b1, `MPP_OFS_ANA_WAKE_EN, 32'h0000_0001);
      apb(1'b1, `MPP_OFS_WAKE_EN, 32'h0000_0004);
      ext_drv <= 8'hff;
      repeat (4) @(posedge pclk);
      for (int k = 0; k < 5; k++) edge_chk(k);
      $display("test events done");
      // output bit falling must not wake
      d1 = 8'($random(seed)) & 8'hfb;
      apb(1'b1, `MPP_OFS_WAKE_DATA, 32'(d1));
      apb(1'b1, `MPP_OFS_WAKE_DIR, 32'h0000_000f);
      settle;
      chk(32'({woe, wo, ev}), 32'({8'h0f, d1, 5'h00}));
      apb(1'b0, `MPP_OFS_WAKE_DATA, 32'h0);
      chk(rd, 32'({4'hf, d1[3:0]}));
      $display("test wake port done");
      final_report;
   end
endmodule
`default_nettype wire
